/* ldsc_pkg.sv */
// Constants and types for the line driver serial control and status port
package ldsc_pkg;

	// Width of the shift register, control latch and status word
	localparam int CTRL_WIDTH = 10;
	// Control latch value after reset: every channel forward active
	localparam logic [9:0] CTRL_RESET = 10'h000;
	// Shift register value after system reset
	localparam logic [9:0] SHIFT_RESET = 10'h000;
	// Stages of every pin synchroniser
	localparam int SYNC_STAGES = 2;
	// Number of pins sampled from the host side
	localparam int PIN_COUNT = 4;
	// Bit positions of the sampled host pins
	localparam int PIN_CLOCK = 0;
	localparam int PIN_ENABLE = 1;
	localparam int PIN_DATA = 2;
	localparam int PIN_RESET = 3;
	// Detectors per channel and their index in a detector group
	localparam int DET_COUNT = 4;
	localparam int DET_LOOP_LOW = 0;
	localparam int DET_LOOP_HIGH = 1;
	localparam int DET_RING_LOW = 2;
	localparam int DET_RING_HIGH = 3;
	// Width of one channel's raw comparator group
	localparam int RAW_WIDTH = 9;

	// Operating state of one channel's line driver
	typedef enum logic [2:0] {
		ldsc_forward_active,
		ldsc_raised_common_mode,
		ldsc_reverse_active,
		ldsc_wink,
		ldsc_scan,
		ldsc_ringing,
		ldsc_tip_open,
		ldsc_disconnect
	} ldsc_line_state_e;

	// Control word, d0 in the lowest bit
	typedef struct packed {
		logic test_load_ch2;
		logic test_load_ch1;
		logic current_limit_ch2;
		logic current_limit_ch1;
		logic [2:0] line_state_ch2;
		logic [2:0] line_state_ch1;
	} ldsc_ctrl_s;

	// Status flags of one channel, first shifted bit lowest
	typedef struct packed {
		logic thermal_ok_flag;
		logic ring_trip_high_flag;
		logic ring_trip_low_flag;
		logic loop_closure_high_flag;
		logic loop_closure_low_flag;
	} ldsc_chan_status_s;

	// Status word, channel 1 in d0 to d4
	typedef struct packed {
		ldsc_chan_status_s ch2;
		ldsc_chan_status_s ch1;
	} ldsc_status_s;

	// Raw comparator outputs of one channel
	typedef struct packed {
		logic thermal_shutdown;
		logic [3:0] above_release;
		logic [3:0] above_trip;
	} ldsc_det_raw_s;

endpackage : ldsc_pkg

/* ldsc_serial_port.sv */
// Serial control and status port of a dual channel line driver
//
// Contract
// - Ten bit shift register plus ten bit latch
// - Idle shifting echoes input ten clocks later
// - Static enable never changes the latch
// - Enable rise loads all ten status bits
// - Status bit d0 appears at once
// - After status, output echoes delayed input
// - Second clock after enable rise captures data
// - Enable fall copies shift register to latch
// - Only enable fall or reset low updates the latch
// - Reset low forces latch to zero
// - Reset low freezes enable edge actions
// - Reset leaves shift register contents untouched
// - Reset and enable low keep shifting
// - Reset low, enable high holds register
// - Control layout: states, limits, test loads
// - Status layout: five flags per channel
// - Three bit line state decode, d0 first
// - Limit bit selects low or high limit
// - Test load bit one turns switch on
// - Thermal bit low means thermal shutdown
// - Loop closure bit low above threshold
// - Ring trip bit low above threshold
// - Detections clear below threshold minus hysteresis
// - Detectors run in every line state
`timescale 1ns/1ps
`default_nettype none

module ldsc_serial_port
	import ldsc_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_serial_clock,
	input wire logic i_serial_enable,
	input wire logic i_serial_data,
	input wire logic i_serial_reset_n,
	input wire ldsc_det_raw_s i_detect_ch1,
	input wire ldsc_det_raw_s i_detect_ch2,
	output logic o_serial_data,
	output var ldsc_ctrl_s o_control,
	output var ldsc_line_state_e o_line_state_ch1,
	output var ldsc_line_state_e o_line_state_ch2
);

	// Map a three bit field, d0 read first, to a line state
	function automatic ldsc_line_state_e decode_state(input logic [2:0] field);
		logic [2:0] code;
		ldsc_line_state_e state;
		code = {field[0], field[1], field[2]};
		unique case (code)
			3'h0: state = ldsc_forward_active;
			3'h1: state = ldsc_raised_common_mode;
			3'h2: state = ldsc_reverse_active;
			3'h3: state = ldsc_wink;
			3'h4: state = ldsc_scan;
			3'h5: state = ldsc_ringing;
			3'h6: state = ldsc_tip_open;
			3'h7: state = ldsc_disconnect;
		endcase
		return state;
	endfunction : decode_state

	// Next detection state from trip and release comparators
	function automatic logic [3:0] hysteresis(input logic [3:0] held,
			input logic [3:0] above_trip, input logic [3:0] above_release);
		return above_trip | (held & above_release);
	endfunction : hysteresis

	// First stage of the host pin synchroniser
	logic [PIN_COUNT-1:0] pin_meta;
	// Second stage, the only copy logic may read
	logic [PIN_COUNT-1:0] pin_sync;
	// Previous serial clock level for edge finding
	logic prev_clock;
	// Previous enable level for edge finding
	logic prev_enable;
	// First stage of the comparator synchroniser
	logic [2*RAW_WIDTH-1:0] det_meta;
	// Second stage of the comparator synchroniser
	logic [2*RAW_WIDTH-1:0] det_sync;
	// Held detections, one bit per detector
	logic [DET_COUNT-1:0] held_ch1;
	logic [DET_COUNT-1:0] held_ch2;
	// Serial shift register, bit 0 drives the output pin
	// ten bit register
	logic [CTRL_WIDTH-1:0] shifter;
	// Parallel control latch
	// separate control latch
	ldsc_ctrl_s control;
	// Set by a status load, cleared by the next clock rise
	logic skip_edge;

	// Synchronised comparator groups
	ldsc_det_raw_s det_ch1;
	ldsc_det_raw_s det_ch2;
	assign det_ch1 = det_sync[RAW_WIDTH-1:0];
	assign det_ch2 = det_sync[2*RAW_WIDTH-1:RAW_WIDTH];

	// Synchronised pins and their edges
	wire serial_reset_n = pin_sync[PIN_RESET];
	wire enable_level = pin_sync[PIN_ENABLE];
	wire serial_bit = pin_sync[PIN_DATA];
	// Serial clock rise, one cycle after the level settles
	// rising edge
	wire clock_rise = pin_sync[PIN_CLOCK] & ~prev_clock;
	// Enable edges; both edge finders clear low like the idle pins
	wire enable_rise = enable_level & ~prev_enable;
	wire enable_fall = ~enable_level & prev_enable;

	// Enable actions only while the serial reset pin is high
	// frozen edges
	wire load_status = enable_rise & serial_reset_n;
	wire latch_control = enable_fall & serial_reset_n;
	// Serial reset stops the clock only while enable is high
	// hold in reset
	wire hold_in_reset = ~serial_reset_n & enable_level;
	// A shift needs a clock rise that is not the swallowed one
	// idle shifting
	wire do_shift = clock_rise & ~hold_in_reset & ~skip_edge & ~load_status;

	// Next held detections
	// release hysteresis
	wire [DET_COUNT-1:0] next_held_ch1 =
		hysteresis(held_ch1, det_ch1.above_trip, det_ch1.above_release);
	wire [DET_COUNT-1:0] next_held_ch2 =
		hysteresis(held_ch2, det_ch2.above_trip, det_ch2.above_release);

	// Status word assembled from registered state only
	// Held flags lag the thermal flag by one comparator sample, so a load mixes two samples
	// single cycle snapshot
	ldsc_status_s status_word;
	assign status_word.ch1.loop_closure_low_flag = ~held_ch1[DET_LOOP_LOW];
	assign status_word.ch1.loop_closure_high_flag = ~held_ch1[DET_LOOP_HIGH];
	assign status_word.ch1.ring_trip_low_flag = ~held_ch1[DET_RING_LOW];
	assign status_word.ch1.ring_trip_high_flag = ~held_ch1[DET_RING_HIGH];
	assign status_word.ch1.thermal_ok_flag = ~det_ch1.thermal_shutdown;
	assign status_word.ch2.loop_closure_low_flag = ~held_ch2[DET_LOOP_LOW];
	assign status_word.ch2.loop_closure_high_flag = ~held_ch2[DET_LOOP_HIGH];
	assign status_word.ch2.ring_trip_low_flag = ~held_ch2[DET_RING_LOW];
	assign status_word.ch2.ring_trip_high_flag = ~held_ch2[DET_RING_HIGH];
	assign status_word.ch2.thermal_ok_flag = ~det_ch2.thermal_shutdown;

	// Next shift register value
	// status load
	wire [CTRL_WIDTH-1:0] next_shifter =
		load_status ? status_word :
		do_shift ? {serial_bit, shifter[CTRL_WIDTH-1:1]} : shifter;

	// Next control latch value
	// reset clears latch
	wire [CTRL_WIDTH-1:0] next_control =
		~serial_reset_n ? CTRL_RESET :
		latch_control ? shifter : control;

	// Next skip marker
	wire next_skip_edge = load_status | (skip_edge & ~clock_rise & serial_reset_n);

	// Pin and comparator synchronisers
	// Chains clear low, so serial reset reads low for two cycles after
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			pin_meta <= '0;
			pin_sync <= '0;
			det_meta <= '0;
			det_sync <= '0;
		end else begin
			pin_meta <= {i_serial_reset_n, i_serial_data, i_serial_enable, i_serial_clock};
			pin_sync <= pin_meta;
			det_meta <= {i_detect_ch2, i_detect_ch1};
			det_sync <= det_meta;
		end
	end

	// Edge finders
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			prev_clock <= 1'b0;
			prev_enable <= 1'b0;
		end else begin
			prev_clock <= pin_sync[PIN_CLOCK];
			prev_enable <= enable_level;
		end
	end

	// Detectors, updated whatever the line state
	// always active
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			held_ch1 <= '0;
			held_ch2 <= '0;
		end else begin
			held_ch1 <= next_held_ch1;
			held_ch2 <= next_held_ch2;
		end
	end

	// Shift register; the serial reset pin never clears it
	// contents kept
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			// Known start value after system reset
			shifter <= SHIFT_RESET;
			skip_edge <= 1'b0;
		end else begin
			shifter <= next_shifter;
			skip_edge <= next_skip_edge;
		end
	end

	// Control latch
	// copy on fall
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			control <= CTRL_RESET;
		end else begin
			control <= next_control;
		end
	end

	// Output pin follows the lowest shift register bit
	// d0 out first
	assign o_serial_data = shifter[0];
	assign o_control = control;
	assign o_line_state_ch1 = decode_state(control.line_state_ch1);
	assign o_line_state_ch2 = decode_state(control.line_state_ch2);

	// Checks on the design's own behaviour
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);

	// Reset low leads to a cleared latch
	property p_reset_clears;
		!serial_reset_n |=> (control == CTRL_RESET);
	endproperty
	a_reset_clears: assert property (p_reset_clears)
		else $error("control latch not cleared while reset low");

	// Without an enable fall the latch stays put
	property p_latch_static;
		(serial_reset_n && !enable_fall) |=> $stable(control);
	endproperty
	a_latch_static: assert property (p_latch_static)
		else $error("control latch changed without enable fall");

	// An enable fall copies the shift register
	property p_latch_copy;
		(serial_reset_n && enable_fall) |=> (control == $past(shifter));
	endproperty
	a_latch_copy: assert property (p_latch_copy)
		else $error("control latch does not match shift register");

	// An enable rise loads the status snapshot
	property p_status_load;
		(serial_reset_n && enable_rise) |=> (shifter == $past(status_word));
	endproperty
	a_status_load: assert property (p_status_load)
		else $error("status word not loaded on enable rise");

	// Status bit d0 reaches the pin right after the load
	property p_first_bit;
		(serial_reset_n && enable_rise) |=> (o_serial_data == $past(status_word[0]));
	endproperty
	a_first_bit: assert property (p_first_bit)
		else $error("first status bit not on serial output");

	// The first clock rise after a load shifts nothing
	property p_skip_first;
		(skip_edge && clock_rise && serial_reset_n) |=> ($stable(shifter) && !skip_edge);
	endproperty
	a_skip_first: assert property (p_skip_first)
		else $error("first clock after enable rise moved data");

	// Reset low with enable high holds the register
	property p_hold_reset;
		(!serial_reset_n && enable_level) |=> $stable(shifter);
	endproperty
	a_hold_reset: assert property (p_hold_reset)
		else $error("shift register changed while held in reset");

	// Reset low with enable low still shifts
	property p_shift_reset;
		(!serial_reset_n && !enable_level && clock_rise && !skip_edge)
			|=> (shifter == {$past(serial_bit), $past(shifter[CTRL_WIDTH-1:1])});
	endproperty
	a_shift_reset: assert property (p_shift_reset)
		else $error("shift register did not shift in reset");

	// Outside reset a plain clock rise moves one bit toward the pin
	property p_idle_shift;
		(serial_reset_n && do_shift)
			|=> (shifter == {$past(serial_bit), $past(shifter[CTRL_WIDTH-1:1])});
	endproperty
	a_idle_shift: assert property (p_idle_shift)
		else $error("shift register did not shift one place");

	// An enable rise in serial reset arms no skip and loads nothing
	property p_frozen_load;
		(!serial_reset_n && enable_rise) |=> !skip_edge;
	endproperty
	a_frozen_load: assert property (p_frozen_load)
		else $error("enable rise acted while serial reset low");

	// A tripped detector stays tripped above its release level
	property p_hysteresis_hold;
		(held_ch1[DET_LOOP_LOW] && det_ch1.above_release[DET_LOOP_LOW])
			|=> held_ch1[DET_LOOP_LOW];
	endproperty
	a_hysteresis_hold: assert property (p_hysteresis_hold)
		else $error("detection released above release level");

	// Main scenarios
	// Status snapshot taken and control word latched
	c_status_load: cover property (serial_reset_n && enable_rise);
	c_latch_update: cover property (latch_control ##1 control != CTRL_RESET);
	// Shifting and holding while the serial reset pin is low
	c_reset_shift: cover property (!serial_reset_n && do_shift);
	c_held_in_reset: cover property (hold_in_reset && clock_rise);
	// A ring trip detection that releases
	c_detect_release: cover property (held_ch2[DET_RING_HIGH] ##1 !held_ch2[DET_RING_HIGH]);

endmodule : ldsc_serial_port

`default_nettype wire

/* ldsc_host.sv */
// Host model driving the serial control port pins
`timescale 1ns/1ps
`default_nettype none

module ldsc_host (
	input wire logic i_clock,
	input wire logic i_link_return,
	output logic o_link_clock,
	output logic o_link_enable,
	output logic o_link_data,
	output logic o_link_reset_n
);
	// Half period of the 200 ns link clock in system clocks
	localparam int HALF = 4;

	// Link idle: clock low, enable low, reset released
	initial begin
		o_link_clock = 1'b0;
		o_link_enable = 1'b0;
		o_link_data = 1'b0;
		o_link_reset_n = 1'b1;
	end

	// Wait n system clocks
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
	endtask : tick

	// Drive the serial reset pin
	task automatic set_reset(input logic level);
		o_link_reset_n <= level;
	endtask : set_reset

	// Clock n bits in, sampling the return line just before each rise
	task automatic clock_bits(input int n, input logic [19:0] din, output logic [19:0] dout);
		dout = 20'h00000;
		for (int i = 0; i < n; i++) begin
			o_link_data <= din[i];
			tick(HALF);
			dout[i] = i_link_return;
			o_link_clock <= 1'b1;
			tick(HALF);
			o_link_clock <= 1'b0;
		end
	endtask : clock_bits

	// One frame: enable rise, swallowed rise, ten data bits, enable fall
	// dummy rise then ten
	task automatic frame(input logic [9:0] ctrl, output logic [10:0] seen);
		logic [19:0] dout;
		o_link_enable <= 1'b1;
		tick(HALF);
		clock_bits(11, {9'h000, ctrl, ~ctrl[0]}, dout);
		tick(HALF);
		o_link_enable <= 1'b0;
		tick(HALF);
		seen = dout[10:0];
	endtask : frame
endmodule : ldsc_host

`default_nettype wire

/* tb_top.sv */
// Testbench for the line driver serial control port
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import ldsc_pkg::*;

	logic clock = 1'b0;
	logic resetn = 1'b0;
	// Host side link wires
	logic sclk, sen, sdin, srst_n, sdout;
	ldsc_det_raw_s det1 = 9'h000;
	ldsc_det_raw_s det2 = 9'h000;
	ldsc_ctrl_s ctrl;
	ldsc_line_state_e ls1, ls2;
	// Expected held detections per channel
	logic [3:0] hold1 = 4'h0;
	logic [3:0] hold2 = 4'h0;
	logic [9:0] last_ctrl = 10'h000;
	int num_errors = 0;
	int checks_done = 0;

	// System clock, 25 ns
	always #12.5 clock = ~clock;

	ldsc_serial_port u_dut (
		.i_clock(clock), .i_resetn(resetn), .i_serial_clock(sclk),
		.i_serial_enable(sen), .i_serial_data(sdin), .i_serial_reset_n(srst_n),
		.i_detect_ch1(det1), .i_detect_ch2(det2), .o_serial_data(sdout),
		.o_control(ctrl), .o_line_state_ch1(ls1), .o_line_state_ch2(ls2)
	);

	ldsc_host u_host (
		.i_clock(clock), .i_link_return(sdout), .o_link_clock(sclk),
		.o_link_enable(sen), .o_link_data(sdin), .o_link_reset_n(srst_n)
	);

	// Compare one value and count it
	task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// Print the counts and the verdict, then stop
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	// Frames over all line state codes twice, every detector bit toggling
	task automatic t_frames();
		logic [10:0] seen;
		ldsc_ctrl_s w;
		ldsc_status_s st;
		for (int c = 0; c < 16; c++) begin
			det1 <= {c[0], 4'(15 - c), 4'(c)};
			det2 <= {c[1], 4'(c), 4'(~c)};
			hold1 = 4'(c) | (hold1 & 4'(15 - c));
			hold2 = 4'(~c) | (hold2 & 4'(c));
			w = {c[2], c[1], ~c[0], c[0], 3'(7 - c), 3'(c)};
			st = {~c[1], ~hold2, ~c[0], ~hold1};
			u_host.tick(4);
			u_host.frame(w, seen);
			u_host.tick(6);
			check("status", {1'b0, st}, {1'b0, seen[10:1]});
			check("status d0 early", {10'h000, st[0]}, {10'h000, seen[0]});
			check("control", {1'b0, w}, {1'b0, ctrl});
			check("state ch1", {8'h00, w[0], w[1], w[2]}, {8'h00, ls1});
			check("state ch2", {8'h00, w[3], w[4], w[5]}, {8'h00, ls2});
			last_ctrl = w;
		end
	endtask : t_frames

	// Idle shifting echoes the input and leaves the latch alone
	task automatic t_echo(input logic [19:0] p);
		logic [19:0] d;
		u_host.clock_bits(20, p, d);
		check("echo", {1'b0, p[9:0]}, {1'b0, d[19:10]});
		check("latch steady", {1'b0, last_ctrl}, {1'b0, ctrl});
	endtask : t_echo

	// Serial reset clears the latch, freezes enable, keeps the register
	task automatic t_serial_reset();
		logic [10:0] seen;
		logic [19:0] d;
		u_host.set_reset(1'b0);
		u_host.tick(6);
		check("reset latch", 11'h000, {1'b0, ctrl});
		u_host.frame(10'h3ff, seen);
		u_host.tick(6);
		check("frozen latch", 11'h000, {1'b0, ctrl});
		check("held register", {11{seen[0]}}, seen);
		last_ctrl = 10'h000;
		t_echo(20'h3c9a5);
		u_host.set_reset(1'b1);
		u_host.tick(6);
		u_host.clock_bits(10, 20'h00000, d);
		check("register kept", {1'b0, 10'(20'h3c9a5 >> 10)}, {1'b0, d[9:0]});
	endtask : t_serial_reset

	// Main sequence
	initial begin
		u_host.tick(4);
		resetn <= 1'b1;
		u_host.tick(6);
		check("reset control", 11'h000, {1'b0, ctrl});
		check("reset state", {8'h00, ldsc_forward_active}, {8'h00, ls1});
		t_frames();
		t_echo(20'h5a36c);
		t_serial_reset();
		conclude();
	end

	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		conclude();
	end
endmodule : tb_top

`default_nettype wire
